//--- verilog/cpw_cfg.svh
/*
  Timing counts, reset values and fixed figures of the capacitance PWM
  output stage with two-point span calibration.
  Assumes a single 100 MHz core clock; all counts derive from it.
*/
`ifndef CPW_CFG_SVH
`define CPW_CFG_SVH

`define CPW_CLK_HZ 100000000
`define CPW_CYC_PER_US (`CPW_CLK_HZ / 1000000)
`define CPW_PWM_FREQ_HZ 100000
`define CPW_PWM_TOL_PCT 7
`define CPW_PWM_PERIOD_CYC (`CPW_CLK_HZ / `CPW_PWM_FREQ_HZ)
`define CPW_PU_TIME_MS 300
`define CPW_PU_CYC (`CPW_PU_TIME_MS * 1000 * `CPW_CYC_PER_US)
`define CPW_CAL_PRESS_US 2500
`define CPW_CAL_PRESS_CYC (`CPW_CAL_PRESS_US * `CPW_CYC_PER_US)
`define CPW_BURST_GAP_US 2500
`define CPW_BURST_GAP_CYC (`CPW_BURST_GAP_US * `CPW_CYC_PER_US)
`define CPW_CAL_SAMPLES 15
`define CPW_CODE_MAX 8'hFF
`define CPW_EP_LO_RESET 16'h0000
`define CPW_EP_HI_RESET 16'hFFFF

`endif

//--- verilog/cpw_pkg.sv
/*
  Types shared by the capacitance PWM calibration block.
  Assumes the constants header is included by the modules that need it.
*/
package cpw_pkg;

  typedef enum logic [4:0] {
    CPW_ST_IDLE    = 5'b0_0001,
    CPW_ST_PRESS   = 5'b0_0010,
    CPW_ST_HOLD    = 5'b0_0100,
    CPW_ST_RELEASE = 5'b0_1000,
    CPW_ST_STORE   = 5'b1_0000
  } cpw_state_t;

  typedef enum logic {
    CPW_EP_LOW  = 1'b0,
    CPW_EP_HIGH = 1'b1
  } cpw_ep_sel_t;

endpackage

//--- verilog/cpw_nvm.sv
/*
  Two-word endpoint store standing in for the non-volatile cells.
  Assumes one write strobe per store; both words are read out of
  registers every cycle, so a write shows two cycles after its strobe.
*/
`timescale 1ns/1ns
`include "cpw_cfg.svh"

module cpw_nvm
  import cpw_pkg::*;
#(
  parameter int SW = 16
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire cpw_ep_sel_t wr_sel_i,
  input wire logic [SW-1:0] wr_data_i,
  output logic [SW-1:0] ep_lo_o,
  output logic [SW-1:0] ep_hi_o
);

  logic [SW-1:0] mem_reg [2];

  // Reset stands for the erased factory state of the cells
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_reg[0] <= SW'(`CPW_EP_LO_RESET);
      mem_reg[1] <= SW'(`CPW_EP_HI_RESET);
    end else if (wr_en_i) begin
      mem_reg[wr_sel_i] <= wr_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ep_lo_o <= SW'(`CPW_EP_LO_RESET);
      ep_hi_o <= SW'(`CPW_EP_HI_RESET);
    end else begin
      ep_lo_o <= mem_reg[0];
      ep_hi_o <= mem_reg[1];
    end
  end

endmodule

//--- verilog/cpw_top.sv
/*
  PWM output stage and two-point span calibration of a capacitance
  converter. Holds the calibration state machine, burst pacing, span
  mapping and the 100 kHz PWM generator; endpoints live in cpw_nvm.
  Assumes the acquisition logic sits on mclk_i, starts a burst on
  burst_req_o and reports each finished burst with sample_valid_i.
  Calibration lines are open-source pins with external pull-downs.
*/
`timescale 1ns/1ns
`include "cpw_cfg.svh"

module cpw_top
  import cpw_pkg::*;
#(
  parameter int SW = 16,
  parameter int PU_CYC = `CPW_PU_CYC,
  parameter int PRESS_CYC = `CPW_CAL_PRESS_CYC,
  parameter int GAP_CYC = `CPW_BURST_GAP_CYC
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic sample_valid_i,
  input wire logic [SW-1:0] sample_i,
  input wire logic low_endpoint_learn_line_i,
  output logic low_endpoint_learn_line_o,
  output logic low_endpoint_learn_line_oe_o,
  input wire logic high_endpoint_learn_line_i,
  output logic high_endpoint_learn_line_o,
  output logic high_endpoint_learn_line_oe_o,
  output logic burst_req_o,
  output logic ready_o,
  output logic cal_busy_o,
  output logic [7:0] result_o,
  output logic pwm_o
);

  localparam int PERIOD = `CPW_PWM_PERIOD_CYC;
  localparam int CW = 25;

  if (SW < 8 || SW > 24 || PU_CYC < 1 || PU_CYC >= 2**CW ||
      PRESS_CYC < 1 || PRESS_CYC >= 2**CW ||
      GAP_CYC < 1 || GAP_CYC >= 2**CW || PERIOD > 4095) begin : g_chk
    $error("cpw_top: parameter out of range");
  end

  function automatic logic [7:0] span_code(input logic [SW-1:0] s,
      input logic [SW-1:0] lo, input logic [SW-1:0] hi);
    logic [SW+7:0] num;
    num = (SW+8)'(s - lo) * (SW+8)'(255);
    if (s <= lo) span_code = 8'h00;
    else if (s >= hi) span_code = `CPW_CODE_MAX;
    else span_code = 8'(num / (SW+8)'(hi - lo));
  endfunction

  function automatic logic [11:0] duty_cycles(input logic [7:0] code);
    logic [19:0] prod;
    prod = 20'(code) * 20'(PERIOD);
    duty_cycles = 12'(prod / 20'(255));
  endfunction

  // Reset release through two flops
  logic rst_a_reg;
  logic rst_n;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_a_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_n <= rst_a_reg;
    end
  end

  // Pin synchronisers; only the second stage is read
  logic lo_s1_reg, lo_s2_reg, hi_s1_reg, hi_s2_reg;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      lo_s1_reg <= 1'b0;
      lo_s2_reg <= 1'b0;
      hi_s1_reg <= 1'b0;
      hi_s2_reg <= 1'b0;
    end else begin
      lo_s1_reg <= low_endpoint_learn_line_i;
      lo_s2_reg <= lo_s1_reg;
      hi_s1_reg <= high_endpoint_learn_line_i;
      hi_s2_reg <= hi_s1_reg;
    end
  end

  // Power-up delay
  logic [CW-1:0] pu_cnt_reg;
  logic ready_reg;
  wire pu_done = pu_cnt_reg == CW'(PU_CYC - 1);
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pu_cnt_reg <= '0;
      ready_reg <= 1'b0;
    end else if (!ready_reg) begin
      pu_cnt_reg <= pu_cnt_reg + CW'(1);
      ready_reg <= pu_done;
    end
  end
  wire ready_rise = !ready_reg && pu_done;

  // Burst pacing: gap counted from the end of the previous burst
  logic [CW-1:0] gap_cnt_reg;
  logic gap_run_reg;
  wire gap_done = gap_run_reg && gap_cnt_reg == '0;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt_reg <= '0;
      gap_run_reg <= 1'b0;
    end else if (ready_reg && sample_valid_i) begin
      gap_cnt_reg <= CW'(GAP_CYC - 1);
      gap_run_reg <= 1'b1;
    end else if (gap_run_reg) begin
      gap_cnt_reg <= gap_cnt_reg - CW'(1);
      gap_run_reg <= !gap_done;
    end
  end
  assign burst_req_o = ready_rise || gap_done;

  // Calibration state machine
  cpw_state_t state_reg, state_next;
  cpw_ep_sel_t sel_reg, sel_next;
  logic [CW-1:0] press_cnt_reg;
  logic [3:0] smp_cnt_reg;
  logic [SW+3:0] acc_reg;
  logic [SW-1:0] ep_lo, ep_hi;

  wire line_sel = (sel_reg == CPW_EP_HIGH) ? hi_s2_reg : lo_s2_reg;
  wire press_done = press_cnt_reg == CW'(PRESS_CYC - 1);
  wire last_smp = sample_valid_i &&
                  smp_cnt_reg == 4'(`CPW_CAL_SAMPLES - 1);
  wire store_en = state_reg == CPW_ST_STORE;
  wire [SW-1:0] learned = SW'(acc_reg / (SW+4)'(`CPW_CAL_SAMPLES));

  always_comb begin
    state_next = state_reg;
    sel_next = sel_reg;
    unique case (state_reg)
      CPW_ST_IDLE: begin
        // Low line has priority only on an exact tie
        if (ready_reg && lo_s2_reg) begin
          state_next = CPW_ST_PRESS;
          sel_next = CPW_EP_LOW;
        end else if (ready_reg && hi_s2_reg) begin
          state_next = CPW_ST_PRESS;
          sel_next = CPW_EP_HIGH;
        end
      end
      CPW_ST_PRESS: begin
        if (!line_sel) state_next = CPW_ST_IDLE;
        else if (press_done) state_next = CPW_ST_HOLD;
      end
      CPW_ST_HOLD: if (last_smp) state_next = CPW_ST_RELEASE;
      CPW_ST_RELEASE: if (!line_sel) state_next = CPW_ST_STORE;
      CPW_ST_STORE: state_next = CPW_ST_IDLE;
      default: state_next = CPW_ST_IDLE;
    endcase
  end

  // sel_reg only changes in idle, so the other line is ignored
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CPW_ST_IDLE;
      sel_reg <= CPW_EP_LOW;
    end else begin
      state_reg <= state_next;
      sel_reg <= sel_next;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      press_cnt_reg <= '0;
      smp_cnt_reg <= '0;
      acc_reg <= '0;
    end else if (state_reg != CPW_ST_HOLD) begin
      press_cnt_reg <= (state_reg == CPW_ST_PRESS) ?
                       press_cnt_reg + CW'(1) : '0;
      smp_cnt_reg <= '0;
      acc_reg <= (state_reg == CPW_ST_RELEASE) ? acc_reg : '0;
    end else if (sample_valid_i) begin
      smp_cnt_reg <= smp_cnt_reg + 4'd1;
      acc_reg <= acc_reg + (SW+4)'(sample_i);
    end
  end

  // Line drive: high only, never low
  wire drive_line = state_reg == CPW_ST_HOLD;
  assign low_endpoint_learn_line_oe_o = drive_line && sel_reg == CPW_EP_LOW;
  assign high_endpoint_learn_line_oe_o =
         drive_line && sel_reg == CPW_EP_HIGH;
  assign low_endpoint_learn_line_o = 1'b1;
  assign high_endpoint_learn_line_o = 1'b1;
  assign cal_busy_o = state_reg != CPW_ST_IDLE;
  assign ready_o = ready_reg;

  // Mean of the fifteen bursts is the learned endpoint
  cpw_nvm #(.SW(SW)) u_nvm (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .wr_en_i(store_en),
    .wr_sel_i(sel_reg),
    .wr_data_i(learned),
    .ep_lo_o(ep_lo),
    .ep_hi_o(ep_hi)
  );

  // Result and PWM; the duty is reloaded only at a period boundary
  logic [7:0] code_reg;
  logic [11:0] pcnt_reg, high_reg;
  logic pwm_reg;
  wire code_upd = ready_reg && sample_valid_i && !cal_busy_o;
  wire wrap = pcnt_reg == 12'(PERIOD - 1);
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      code_reg <= 8'h00;
    end else if (code_upd) begin
      code_reg <= span_code(sample_i, ep_lo, ep_hi);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pcnt_reg <= '0;
      high_reg <= '0;
      pwm_reg <= 1'b0;
    end else begin
      pcnt_reg <= wrap ? '0 : pcnt_reg + 12'd1;
      if (wrap) high_reg <= duty_cycles(code_reg);
      pwm_reg <= ready_reg && (wrap ? duty_cycles(code_reg) != '0 :
                 pcnt_reg + 12'd1 < high_reg);
    end
  end
  assign pwm_o = pwm_reg;
  assign result_o = code_reg;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  // Checked step by step: a 1000-cycle delay would be far too long
  pwm_period_a: assert property (
    $past(rst_n) |=>
    pcnt_reg == ($past(wrap) ? 12'd0 : $past(pcnt_reg) + 12'd1))
    else $error("PWM period is not 1000 cycles");
  duty_match_a: assert property (
    ready_reg && !wrap |=> pwm_o == (pcnt_reg < high_reg))
    else $error("PWM high time does not follow duty");
  result_freeze_a: assert property (
    cal_busy_o && $past(cal_busy_o) |-> $stable(code_reg))
    else $error("Result changed during calibration");
  store_sel_a: assert property (
    store_en && sel_reg == CPW_EP_LOW |=> ##1 ep_lo == $past(learned, 2))
    else $error("Low endpoint not stored");
  other_keep_a: assert property (
    store_en && sel_reg == CPW_EP_HIGH |=> ##1 $stable(ep_lo))
    else $error("Low endpoint disturbed by high learn");
  line_drive_a: assert property (
    state_reg == CPW_ST_PRESS && press_done && line_sel
    |=> low_endpoint_learn_line_oe_o || high_endpoint_learn_line_oe_o)
    else $error("Line not held after press time");
  release_done_a: assert property (
    last_smp && state_reg == CPW_ST_HOLD
    |=> !low_endpoint_learn_line_oe_o && !high_endpoint_learn_line_oe_o)
    else $error("Line not released after last sample");
  fifteen_smp_a: assert property (
    state_reg == CPW_ST_HOLD && state_next == CPW_ST_RELEASE
    |-> smp_cnt_reg == 4'd14 && sample_valid_i)
    else $error("Calibration ended on wrong sample count");
  powerup_quiet_a: assert property (
    // The first burst is requested in the last cycle of the delay
    !ready_reg |-> !pwm_o && state_reg == CPW_ST_IDLE &&
    (!burst_req_o || pu_done))
    else $error("Activity during power-up delay");
  burst_gap_a: assert property (
    ready_reg && sample_valid_i ##1 (!sample_valid_i)[*3]
    |-> !burst_req_o)
    else $error("Burst requested inside the gap");
  clamp_low_a: assert property (
    code_upd && sample_i <= ep_lo |=> code_reg == 8'h00)
    else $error("Result below span not clamped");

  cal_low_c: cover property (store_en && sel_reg == CPW_EP_LOW);
  cal_high_c: cover property (store_en && sel_reg == CPW_EP_HIGH);
  press_abort_c: cover property (
    state_reg == CPW_ST_PRESS && state_next == CPW_ST_IDLE);
  full_scale_c: cover property (code_reg == `CPW_CODE_MAX && wrap);

endmodule

//--- dv/cpw_host_model.sv
/*
  Host side of one calibration line: an open-source driver.
  Assumes the bench resolves the line as pull-down OR all high drivers.
*/
`timescale 1ns/1ns
module cpw_host_model (
  input wire logic mclk_i,
  input wire logic line_i,
  output logic drive_o
);
  initial drive_o = 1'b0;
  // Only ever drives high or floats; a low drive would short the pin
  task automatic press(input int cycles);
    @(negedge mclk_i);
    drive_o = 1'b1;
    repeat (cycles) @(negedge mclk_i);
    drive_o = 1'b0;
    // Sense completion: the line floats low once the device lets go
    while (line_i !== 1'b0) @(negedge mclk_i);
  endtask
endmodule

//--- dv/testbench.sv
/*
  Self-checking bench for cpw_top: power-up, span mapping, PWM, burst
  pacing and both calibrations. Assumes shortened counts and pull-downs.
*/
`timescale 1ns/1ns
module testbench;
  localparam int PU = 200;
  localparam int PR = 50;
  localparam int GAP = 40;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic sample_valid_i = 1'b0;
  logic [15:0] sample_i = 16'h0000;
  logic lo_drv, hi_drv, lo_o, lo_oe, hi_o, hi_oe, burst, ready, busy, pwm;
  logic [7:0] res;
  logic [15:0] lo_ep = 16'h0000;
  logic [15:0] hi_ep = 16'hFFFF;
  int seed = 35871;
  int num_errors = 0;
  int checked = 0;
  // Pulled-down lines: any party driving high wins
  wire lo_line = lo_drv | (lo_oe & lo_o);
  wire hi_line = hi_drv | (hi_oe & hi_o);

  initial forever #5 mclk_i = ~mclk_i;

  cpw_top #(.PU_CYC(PU), .PRESS_CYC(PR), .GAP_CYC(GAP)) DUT (
    .mclk_i(mclk_i), .resetn_i(resetn_i),
    .sample_valid_i(sample_valid_i), .sample_i(sample_i),
    .low_endpoint_learn_line_i(lo_line), .low_endpoint_learn_line_o(lo_o),
    .low_endpoint_learn_line_oe_o(lo_oe),
    .high_endpoint_learn_line_i(hi_line), .high_endpoint_learn_line_o(hi_o),
    .high_endpoint_learn_line_oe_o(hi_oe),
    .burst_req_o(burst), .ready_o(ready), .cal_busy_o(busy),
    .result_o(res), .pwm_o(pwm));
  cpw_host_model lo_h (.mclk_i(mclk_i), .line_i(lo_line), .drive_o(lo_drv));
  cpw_host_model hi_h (.mclk_i(mclk_i), .line_i(hi_line), .drive_o(hi_drv));

  function automatic logic [7:0] map(input logic [15:0] s, lo, hi);
    if (s <= lo) return 8'h00;
    if (s >= hi) return 8'hFF;
    return 8'((255 * (int'(s) - int'(lo))) / (int'(hi) - int'(lo)));
  endfunction

  task automatic chk_code(input logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, exp);
    checked++;
    if (got != exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [15:0] s);
    @(negedge mclk_i);
    sample_valid_i = 1'b1;
    sample_i = s;
    @(negedge mclk_i);
    sample_valid_i = 1'b0;
    sample_i = 16'($random(seed));
  endtask

  // Endpoint corners first, then random signal values
  task automatic map_set;
    logic [15:0] s;
    for (int i = 0; i < 8; i++) begin
      s = (i == 0) ? lo_ep - 16'd1 : (i == 1) ? hi_ep + 16'd1 :
          (i == 2) ? lo_ep : (i == 3) ? hi_ep : 16'($random(seed));
      send(s);
      @(negedge mclk_i);
      chk_code(res, map(s, lo_ep, hi_ep));
    end
  endtask

  task automatic chk_gap;
    int n;
    @(negedge mclk_i);
    sample_valid_i = 1'b1;
    @(negedge mclk_i);
    sample_valid_i = 1'b0;
    n = 1;
    while (burst !== 1'b1 && n < GAP + 10) begin
      @(negedge mclk_i);
      n++;
    end
    chk_cnt(n, GAP);
  endtask

  // Any 1000-cycle window over two equal periods holds one full high time
  task automatic chk_pwm(input logic [7:0] code);
    int hi_n;
    int rises;
    logic prev;
    hi_n = 0;
    rises = 0;
    repeat (2000) @(negedge mclk_i);
    prev = pwm;
    repeat (1000) begin
      @(negedge mclk_i);
      if (pwm === 1'b1) hi_n++;
      if (pwm === 1'b1 && prev === 1'b0) rises++;
      prev = pwm;
    end
    chk_cnt(hi_n, (int'(code) * 1000) / 255);
    chk_cnt(rises, 1);
  endtask

  task automatic do_cal(input logic up, input logic [15:0] b);
    int n;
    logic [7:0] held;
    held = res;
    n = 0;
    fork
      if (up) hi_h.press(PR + 20);
      else lo_h.press(PR + 20);
      if (!up) hi_h.press(PR + 20);
    join_none
    while ((up ? hi_oe : lo_oe) !== 1'b1 && n < PR + 50) begin
      @(negedge mclk_i);
      n++;
    end
    chk_bit(n >= PR && n <= PR + 4, 1'b1);
    chk_bit(up ? lo_oe : hi_oe, 1'b0);
    for (int i = 0; i < 15; i++) begin
      send(b + 16'(i));
      if (i == 13) chk_bit(up ? hi_oe : lo_oe, 1'b1);
      if (i == 13) chk_bit(up ? hi_line : lo_line, 1'b1);
    end
    @(negedge mclk_i);
    chk_bit(up ? hi_oe : lo_oe, 1'b0);
    chk_bit(up ? hi_line : lo_line, 1'b0);
    chk_code(res, held);
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(negedge mclk_i);
      n++;
    end
    chk_bit(busy, 1'b0);
    if (up) hi_ep = b + 16'd7;
    else lo_ep = b + 16'd7;
    repeat (3) @(negedge mclk_i);
  endtask

  task automatic end_sim;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    int n;
    logic ok;
    ok = 1'b1;
    n = 0;
    repeat (3) @(negedge mclk_i);
    resetn_i = 1'b1;
    // A full-length press during power-up must be ignored
    fork
      lo_h.press(150);
    join_none
    while (ready !== 1'b1 && n < PU + 50) begin
      @(negedge mclk_i);
      n++;
      if (busy !== 1'b0 || pwm !== 1'b0 || lo_oe !== 1'b0) ok = 1'b0;
    end
    chk_bit(ok, 1'b1);
    chk_bit(n >= PU && n <= PU + 4, 1'b1);
    map_set;
    chk_gap;
    send(16'h8000);
    chk_pwm(map(16'h8000, lo_ep, hi_ep));
    // A press shorter than the press time must abort and store nothing
    fork
      lo_h.press(PR / 2);
    join_none
    repeat (PR + 10) begin
      @(negedge mclk_i);
      if (lo_oe !== 1'b0) ok = 1'b0;
    end
    chk_bit(ok, 1'b1);
    chk_bit(busy, 1'b0);
    do_cal(1'b0, 16'h1000);
    map_set;
    do_cal(1'b1, 16'h9000);
    map_set;
    send(16'h5000);
    chk_pwm(map(16'h5000, lo_ep, hi_ep));
    end_sim;
  end

  // Whole run is under 7k cycles; this leaves ample margin
  initial begin
    #200000;
    num_errors++;
    end_sim;
  end
endmodule
